// ===== dv/lcdcd_ctrl_model.sv
// timing controller model: shift clock, start pulse, pixel buses, latch clock
module lcdcd_ctrl_model (
    input wire clk,
    output reg sclk = 1'b0,
    output reg sp = 1'b0,
    output reg [5:0] b0 = 6'h00,
    output reg [5:0] b1 = 6'h00,
    output reg [5:0] b2 = 6'h00,
    output reg lat = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////////////////
    // one shift edge: two cycles low, two cycles high
    task automatic shift_edge;
        repeat (2) @(posedge clk);
        sclk <= 1'b1;
        repeat (2) @(posedge clk);
        sclk <= 1'b0;
    endtask
    // start pulse over one edge, then one code triple per edge
    task automatic send_line(input int n, input logic [5:0] s);
        int k;
        sp <= 1'b1;
        shift_edge();
        sp <= 1'b0;
        for (k = 1; k <= n; k++) begin
            b0 <= 6'(3 * k + s);
            b1 <= 6'(3 * k + 1 + s);
            b2 <= 6'(3 * k + 2 + s);
            shift_edge();
        end
        b0 <= ~b0;
        b1 <= ~b1;
        b2 <= ~b2;
    endtask
    // latch only once the line is loaded
    task automatic latch_line;
        lat <= 1'b1;
        repeat (2) @(posedge clk);
        lat <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
endmodule

// ===== dv/lcdcd_top_bench.sv
// testbench for the column driver front end
`include "lcdcd_defs.vh"
module lcdcd_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, srst = 1'b1, dir = 1'b1, polarity_invert = 1'b1, sel = 1'b0, tst = 1'b1, so_q = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, sclk, sp, lat, ro, roe, lo, loe;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [5:0] b0, b1, b2;
    wire [1544:0] base, sfrom, sto;
    wire [926:0] step;
    wire [308:0] drv;
    wire rpin = roe ? ro : sp;
    wire lpin = loe ? lo : sp;
    int n_fail = 0, comparisons = 0, n_so = 0;
    always #20 clk = ~clk;
    always @(posedge clk) begin
        so_q <= dir ? lo : ro;
        if ((dir ? lo : ro) && !so_q) n_so <= n_so + 1;
    end
    lcdcd_ctrl_model i_ctrl (.clk(clk), .sclk(sclk), .sp(sp), .b0(b0), .b1(b1), .b2(b2),
        .lat(lat));
    lcdcd_top i_dut (.CLK(clk), .SRST(srst), .SHIFT_CLOCK(sclk), .LINE_LATCH_CLOCK(lat),
        .SHIFT_DIRECTION_SELECT(dir), .RIGHT_START_PULSE_IO_I(rpin),
        .RIGHT_START_PULSE_IO_O(ro), .RIGHT_START_PULSE_IO_OE(roe),
        .LEFT_START_PULSE_IO_I(lpin), .LEFT_START_PULSE_IO_O(lo), .LEFT_START_PULSE_IO_OE(loe),
        .PIXEL_BUS_0(b0), .PIXEL_BUS_1(b1), .PIXEL_BUS_2(b2), .POLARITY_INVERT(polarity_invert),
        .OUTPUT_COUNT_SELECT(sel), .TEST_MODE_N(tst), .CH_BASE_REF(base),
        .CH_SLOPE_FROM(sfrom), .CH_SLOPE_TO(sto), .CH_STEP(step), .CH_DRIVE(drv),
        .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (awready === 1'b1) aw = 1'b1;
            if (aw) awvalid <= 1'b0;
            if (wready === 1'b1) w = 1'b1;
            if (w) wvalid <= 1'b0;
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // every channel against the codes the model sent with seed s, except the short-mode gap channels, which are checked only for drive off
    task automatic chk_ch(input logic [5:0] s);
        int i, g, n, up, sg;
        logic [5:0] c;
        for (i = 0; i < 309; i++) begin
            g = i / 3;
            n = dir ? g + 1 : 103 - g;
            if (sel && dir && g > 52) n = g - 2;
            if (sel && !dir && g < 50) n = 100 - g;
            c = 6'(3 * n + i % 3 + s);
            sg = c[5:3];
            up = ((i % 2 == 0) == polarity_invert);
            if (sel && g > 49 && g < 53) begin
                cmp(drv[i], 1'b0);
            end else begin
                cmp(step[i*3+:3], c[2:0]);
                cmp(base[i*5+:5], up ? sg + 1 : 18 - sg);
                cmp(sfrom[i*5+:5], up ? sg + (sg != 7) : 18 - sg);
                cmp(sto[i*5+:5], up ? sg + 1 + (sg != 7) : 17 - sg);
                cmp(drv[i], 1'b1);
            end
        end
    endtask
    task automatic run_line(input int n, input logic [5:0] s);
        int n0;
        repeat (3) @(posedge clk);
        n0 = n_so;
        i_ctrl.send_line(n, s);
        i_ctrl.latch_line();
        cmp(n_so - n0, n > 102);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_right;
        logic [31:0] d;
        logic [1:0] r;
        run_line(103, 6'h05);
        chk_ch(6'h05);
        axi_rd(`LCDCD_OFF_STATUS, d, r);
        cmp(d[4:0], 5'h11);
        $display("right shift line done");
    endtask
    task automatic t_left;
        dir <= 1'b0;
        i_ctrl.send_line(20, 6'h3f);
        run_line(103, 6'h11);
        chk_ch(6'h11);
        $display("left shift line with restart done");
    endtask
    task automatic t_300;
        sel <= 1'b1;
        run_line(103, 6'h2a);
        chk_ch(6'h2a);
        dir <= 1'b1;
        run_line(103, 6'h22);
        chk_ch(6'h22);
        $display("short count lines done");
    endtask
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(`LCDCD_OFF_CTRL, 32'h0, r);
        cmp(r, `LCDCD_RESP_OKAY);
        run_line(10, 6'h30);
        chk_ch(6'h22);
        axi_wr(`LCDCD_OFF_CTRL, 32'h1, r);
        axi_wr(8'h20, 32'h1, r);
        cmp(r, `LCDCD_RESP_SLVERR);
        axi_rd(8'h20, d, r);
        cmp(d, 32'h0);
        cmp(r, `LCDCD_RESP_SLVERR);
        axi_wr(`LCDCD_OFF_LINES, 32'h0, r);
        axi_rd(`LCDCD_OFF_LINES, d, r);
        cmp(d, 32'h5);
        axi_wr(`LCDCD_OFF_CODE_IDX, 32'h3, r);
        axi_rd(`LCDCD_OFF_CODE_RD, d, r);
        cmp(d, 32'h28);
        $display("register access done");
    endtask
    task automatic t_pol;
        polarity_invert <= 1'b0;
        repeat (3) @(posedge clk);
        chk_ch(6'h22);
        tst <= 1'b0;
        repeat (3) @(posedge clk);
        cmp(|drv, 1'b0);
        tst <= 1'b1;
        $display("polarity and test mode done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 40000);
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        cmp(base[9:0], {5'h12, 5'h01});
        t_right();
        t_left();
        t_300();
        t_regs();
        t_pol();
        print_verdict();
    end
endmodule

// ===== dv/lcdcd_top_sva.sv
// assertions on the column driver front end ports
module lcdcd_top_sva #(
    parameter NUM_CH = 309
) (
    input wire CLK,
    input wire SRST,
    input wire SHIFT_CLOCK,
    input wire LINE_LATCH_CLOCK,
    input wire SHIFT_DIRECTION_SELECT,
    input wire RIGHT_START_PULSE_IO_I,
    input wire RIGHT_START_PULSE_IO_O,
    input wire RIGHT_START_PULSE_IO_OE,
    input wire LEFT_START_PULSE_IO_I,
    input wire LEFT_START_PULSE_IO_O,
    input wire LEFT_START_PULSE_IO_OE,
    input wire OUTPUT_COUNT_SELECT,
    input wire TEST_MODE_N,
    input wire [NUM_CH*3-1:0] CH_STEP,
    input wire [NUM_CH-1:0] CH_DRIVE
);
    timeunit 1ns;
    timeprecision 1ns;
    reg sc_q_r;
    reg [7:0] cnt_r;
    wire dir = SHIFT_DIRECTION_SELECT;
    wire sedge = SHIFT_CLOCK & ~sc_q_r;
    wire sin = dir ? RIGHT_START_PULSE_IO_I : LEFT_START_PULSE_IO_I;
    wire sout = dir ? LEFT_START_PULSE_IO_O : RIGHT_START_PULSE_IO_O;
    ////////////////////////////////////////////////////////////////////////////////
    // shift edges since the last arming edge
    always @(posedge CLK) begin
        if (SRST) begin
            sc_q_r <= 1'b0;
            cnt_r <= 8'hff;
        end else begin
            sc_q_r <= SHIFT_CLOCK;
            if (sedge && sin)
                cnt_r <= 8'h00;
            else if (sedge && cnt_r < 8'hc8)
                cnt_r <= cnt_r + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);
    property p_oe_follow;
        !$past(SRST) |-> LEFT_START_PULSE_IO_OE == $past(dir);
    endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("left enable off");
    property p_oe_pair;
        !$past(SRST) |-> RIGHT_START_PULSE_IO_OE != LEFT_START_PULSE_IO_OE;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("both pins same enable");
    property p_idle_out;
        !$past(SRST) && $past(dir) |-> !RIGHT_START_PULSE_IO_O;
    endproperty
    a_idle_out: assert property (p_idle_out) else $error("input pin driven high");
    property p_so_103;
        sedge && cnt_r == 8'h65 && !sin |-> ##2 sout;
    endproperty
    a_so_103: assert property (p_so_103) else $error("start out late");
    property p_so_hold;
        $rose(sout) |=> sout;
    endproperty
    a_so_hold: assert property (p_so_hold) else $error("start out too short");
    property p_test_cut;
        !$past(SRST) && !$past(TEST_MODE_N) |-> CH_DRIVE == '0;
    endproperty
    a_test_cut: assert property (p_test_cut) else $error("drive in test mode");
    property p_gap;
        !$past(SRST) && $past(OUTPUT_COUNT_SELECT) |-> CH_DRIVE[158:150] == 9'h000;
    endproperty
    a_gap: assert property (p_gap) else $error("unused channel driven");
    property p_step_latch;
        $changed(CH_STEP[2:0]) |-> $past(LINE_LATCH_CLOCK, 2) && !$past(LINE_LATCH_CLOCK, 3);
    endproperty
    a_step_latch: assert property (p_step_latch) else $error("code moved without latch");
endmodule
bind lcdcd_top lcdcd_top_sva #(.NUM_CH(NUM_CH)) i_sva (
    .CLK(CLK), .SRST(SRST), .SHIFT_CLOCK(SHIFT_CLOCK), .LINE_LATCH_CLOCK(LINE_LATCH_CLOCK),
    .SHIFT_DIRECTION_SELECT(SHIFT_DIRECTION_SELECT),
    .RIGHT_START_PULSE_IO_I(RIGHT_START_PULSE_IO_I),
    .RIGHT_START_PULSE_IO_O(RIGHT_START_PULSE_IO_O),
    .RIGHT_START_PULSE_IO_OE(RIGHT_START_PULSE_IO_OE),
    .LEFT_START_PULSE_IO_I(LEFT_START_PULSE_IO_I),
    .LEFT_START_PULSE_IO_O(LEFT_START_PULSE_IO_O),
    .LEFT_START_PULSE_IO_OE(LEFT_START_PULSE_IO_OE),
    .OUTPUT_COUNT_SELECT(OUTPUT_COUNT_SELECT), .TEST_MODE_N(TEST_MODE_N),
    .CH_STEP(CH_STEP), .CH_DRIVE(CH_DRIVE)
);

// ===== hw/lcdcd_chan_conv.v
// per-channel reference selection and output drive stage
`include "lcdcd_defs.vh"
module lcdcd_chan_conv (
    input wire clk,
    input wire srst,
    input wire [5:0] code,
    input wire upper_set,
    input wire drive_en,
    output reg [4:0] base_ref,
    output reg [4:0] slope_from,
    output reg [4:0] slope_to,
    output reg [2:0] step,
    output reg drive
);
    wire [2:0] seg = code[5:3];
    wire [4:0] seg5 = {2'h0, seg};
    reg [4:0] base_nxt;
    reg [4:0] from_nxt;
    reg [4:0] to_nxt;

    // upper bits pick the reference pair, lower bits the eighth step
    always @* begin
        if (upper_set) begin
            base_nxt = `LCDCD_REF_UP_FIRST + seg5;
            if (seg == `LCDCD_REF_UP_TOP) begin
                from_nxt = base_nxt - 5'h01;
                to_nxt = base_nxt;
            end else begin
                from_nxt = base_nxt;
                to_nxt = base_nxt + 5'h01;
            end
        end else begin
            base_nxt = `LCDCD_REF_LO_FIRST - seg5;
            from_nxt = base_nxt;
            to_nxt = base_nxt - 5'h01;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            base_ref <= 5'h00;
            slope_from <= 5'h00;
            slope_to <= 5'h00;
            step <= 3'h0;
            drive <= 1'b0;
        end else begin
            base_ref <= base_nxt;
            slope_from <= from_nxt;
            slope_to <= to_nxt;
            step <= code[2:0];
            drive <= drive_en;
        end
    end
endmodule

// ===== hw/lcdcd_defs.vh
// constants for the column driver load and latch front end
`ifndef LCDCD_DEFS_VH
`define LCDCD_DEFS_VH
`define LCDCD_NUM_CH 309
`define LCDCD_NUM_GRP 103
`define LCDCD_GRP_FIRST_R 7'h00
`define LCDCD_GRP_LAST_R 7'h66
`define LCDCD_GRP_SKIP_LO 7'h31
`define LCDCD_GRP_SKIP_HI 7'h35
`define LCDCD_CH_GAP_LO 150
`define LCDCD_CH_GAP_HI 158
`define LCDCD_SO_EDGE 7'h67
`define LCDCD_CODE_W 6
`define LCDCD_REF_W 5
`define LCDCD_REF_UP_FIRST 5'h01
`define LCDCD_REF_LO_FIRST 5'h12
`define LCDCD_REF_UP_TOP 3'h7
`define LCDCD_OFF_CTRL 8'h00
`define LCDCD_OFF_STATUS 8'h04
`define LCDCD_OFF_LINES 8'h08
`define LCDCD_OFF_CODE_IDX 8'h0c
`define LCDCD_OFF_CODE_RD 8'h10
`define LCDCD_CTRL_RST 1'h1
`define LCDCD_RESP_OKAY 2'h0
`define LCDCD_RESP_SLVERR 2'h2
`endif

// ===== hw/lcdcd_top.v
// column driver front end: shift loading, cascade pulse, line latch, bus registers
`include "lcdcd_defs.vh"
module lcdcd_top #(
    parameter NUM_CH = `LCDCD_NUM_CH,
    parameter ADDR_W = 8
) (
    input wire CLK,
    input wire SRST,
    input wire SHIFT_CLOCK,
    input wire LINE_LATCH_CLOCK,
    input wire SHIFT_DIRECTION_SELECT,
    input wire RIGHT_START_PULSE_IO_I,
    output reg RIGHT_START_PULSE_IO_O,
    output reg RIGHT_START_PULSE_IO_OE,
    input wire LEFT_START_PULSE_IO_I,
    output reg LEFT_START_PULSE_IO_O,
    output reg LEFT_START_PULSE_IO_OE,
    input wire [5:0] PIXEL_BUS_0,
    input wire [5:0] PIXEL_BUS_1,
    input wire [5:0] PIXEL_BUS_2,
    input wire POLARITY_INVERT,
    input wire OUTPUT_COUNT_SELECT,
    input wire TEST_MODE_N,
    output wire [NUM_CH*5-1:0] CH_BASE_REF,
    output wire [NUM_CH*5-1:0] CH_SLOPE_FROM,
    output wire [NUM_CH*5-1:0] CH_SLOPE_TO,
    output wire [NUM_CH*3-1:0] CH_STEP,
    output wire [NUM_CH-1:0] CH_DRIVE,
    input wire [ADDR_W-1:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [ADDR_W-1:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY
);
    localparam ST_STANDBY = 3'b001;
    localparam ST_ARMED = 3'b010;
    localparam ST_LOAD = 3'b100;

    ////////////////////////////////////////////////////////////////////////////////
    // pin sampling and edge detection

    reg shift_prev_r;
    reg latch_prev_r;
    wire shift_rise = SHIFT_CLOCK & ~shift_prev_r;
    wire latch_rise = LINE_LATCH_CLOCK & ~latch_prev_r;
    wire dir_right = SHIFT_DIRECTION_SELECT;
    wire start_in = dir_right ? RIGHT_START_PULSE_IO_I : LEFT_START_PULSE_IO_I;
    wire sel300 = OUTPUT_COUNT_SELECT;

    always @(posedge CLK) begin
        if (SRST) begin
            shift_prev_r <= 1'b0;
            latch_prev_r <= 1'b0;
        end else begin
            shift_prev_r <= SHIFT_CLOCK;
            latch_prev_r <= LINE_LATCH_CLOCK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // loading sequencer

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [6:0] ptr_r;
    reg [6:0] ptr_nxt;
    reg [6:0] so_cnt_r;
    reg so_cnt_run_r;
    reg start_out_r;
    reg load_en_r;
    reg [5:0] data_mem [0:NUM_CH-1];
    reg [5:0] latch_mem [0:NUM_CH-1];
    wire [6:0] grp_first = dir_right ? `LCDCD_GRP_FIRST_R : `LCDCD_GRP_LAST_R;
    wire [6:0] grp_last = dir_right ? `LCDCD_GRP_LAST_R : `LCDCD_GRP_FIRST_R;
    wire [8:0] slot = {1'b0, ptr_r, 1'b0} + {2'h0, ptr_r};
    wire take = shift_rise & load_en_r;
    wire capture = take & ~start_in & (state_r == ST_ARMED || state_r == ST_LOAD);

    // next group, stepping over the silent gap in the short mode
    always @* begin
        if (dir_right) begin
            if (sel300 && ptr_r == `LCDCD_GRP_SKIP_LO) begin
                ptr_nxt = `LCDCD_GRP_SKIP_HI;
            end else begin
                ptr_nxt = ptr_r + 7'h01;
            end
        end else begin
            if (sel300 && ptr_r == `LCDCD_GRP_SKIP_HI) begin
                ptr_nxt = `LCDCD_GRP_SKIP_LO;
            end else begin
                ptr_nxt = ptr_r - 7'h01;
            end
        end
    end

    always @* begin
        state_nxt = state_r;
        if (take) begin
            if (start_in) begin
                state_nxt = ST_ARMED;
            end else begin
                case (state_r)
                    ST_ARMED: state_nxt = (ptr_r == grp_last) ? ST_STANDBY : ST_LOAD;
                    ST_LOAD: state_nxt = (ptr_r == grp_last) ? ST_STANDBY : ST_LOAD;
                    ST_STANDBY: state_nxt = ST_STANDBY;
                    default: state_nxt = ST_STANDBY;
                endcase
            end
        end
    end

    always @(posedge CLK) begin
        if (SRST) begin
            state_r <= ST_STANDBY;
            ptr_r <= 7'h00;
        end else begin
            state_r <= state_nxt;
            if (take && start_in) begin
                ptr_r <= grp_first;
            end else if (capture) begin
                ptr_r <= ptr_nxt;
            end
        end
    end

    // three codes go to one channel triple per shift edge
    always @(posedge CLK) begin
        if (capture) begin
            data_mem[slot] <= PIXEL_BUS_0;
            data_mem[slot + 9'h001] <= PIXEL_BUS_1;
            data_mem[slot + 9'h002] <= PIXEL_BUS_2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // cascade start pulse

    always @(posedge CLK) begin
        if (SRST) begin
            so_cnt_r <= 7'h00;
            so_cnt_run_r <= 1'b0;
            start_out_r <= 1'b0;
        end else if (take) begin
            start_out_r <= 1'b0;
            if (start_in) begin
                so_cnt_r <= 7'h00;
                so_cnt_run_r <= 1'b1;
            end else if (so_cnt_run_r) begin
                so_cnt_r <= so_cnt_r + 7'h01;
                if (so_cnt_r + 7'h01 == `LCDCD_SO_EDGE - 7'h01) begin
                    start_out_r <= 1'b1;
                    so_cnt_run_r <= 1'b0;
                end
            end
        end
    end

    always @(posedge CLK) begin
        if (SRST) begin
            RIGHT_START_PULSE_IO_O <= 1'b0;
            RIGHT_START_PULSE_IO_OE <= 1'b0;
            LEFT_START_PULSE_IO_O <= 1'b0;
            LEFT_START_PULSE_IO_OE <= 1'b0;
        end else begin
            RIGHT_START_PULSE_IO_O <= start_out_r & ~dir_right;
            RIGHT_START_PULSE_IO_OE <= ~dir_right;
            LEFT_START_PULSE_IO_O <= start_out_r & dir_right;
            LEFT_START_PULSE_IO_OE <= dir_right;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // line latch and channel stages

    integer k;
    reg [15:0] lines_r;

    always @(posedge CLK) begin
        if (SRST) begin
            for (k = 0; k < NUM_CH; k = k + 1) begin
                latch_mem[k] <= 6'h00;
            end
            lines_r <= 16'h0000;
        end else if (latch_rise) begin
            for (k = 0; k < NUM_CH; k = k + 1) begin
                latch_mem[k] <= data_mem[k];
            end
            lines_r <= lines_r + 16'h0001;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_CH; i = i + 1) begin : g_ch
            wire odd_ch = (i % 2) == 0;
            wire upper = odd_ch ? POLARITY_INVERT : ~POLARITY_INVERT;
            wire in_gap = sel300 && i >= `LCDCD_CH_GAP_LO && i <= `LCDCD_CH_GAP_HI;
            lcdcd_chan_conv u_conv (
                .clk(CLK),
                .srst(SRST),
                .code(latch_mem[i]),
                .upper_set(upper),
                .drive_en(TEST_MODE_N & ~in_gap),
                .base_ref(CH_BASE_REF[i*5 +: 5]),
                .slope_from(CH_SLOPE_FROM[i*5 +: 5]),
                .slope_to(CH_SLOPE_TO[i*5 +: 5]),
                .step(CH_STEP[i*3 +: 3]),
                .drive(CH_DRIVE[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // register bus slave

    reg aw_got_r;
    reg w_got_r;
    reg [ADDR_W-1:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg [8:0] code_idx_r;
    wire wr_fire = aw_got_r & w_got_r & ~S_AXI_BVALID;

    always @(posedge CLK) begin
        if (SRST) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= {ADDR_W{1'b0}};
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `LCDCD_RESP_OKAY;
            load_en_r <= `LCDCD_CTRL_RST;
            code_idx_r <= 9'h000;
        end else begin
            S_AXI_AWREADY <= ~aw_got_r & ~S_AXI_AWREADY & S_AXI_AWVALID;
            S_AXI_WREADY <= ~w_got_r & ~S_AXI_WREADY & S_AXI_WVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= `LCDCD_RESP_OKAY;
                case (aw_addr_r)
                    `LCDCD_OFF_CTRL: begin
                        if (w_strb_r[0]) begin
                            load_en_r <= w_data_r[0];
                        end
                    end
                    `LCDCD_OFF_CODE_IDX: begin
                        if (w_strb_r[0]) begin
                            code_idx_r[7:0] <= w_data_r[7:0];
                        end
                        if (w_strb_r[1]) begin
                            code_idx_r[8] <= w_data_r[8];
                        end
                    end
                    `LCDCD_OFF_STATUS, `LCDCD_OFF_LINES, `LCDCD_OFF_CODE_RD: begin
                        S_AXI_BRESP <= `LCDCD_RESP_OKAY;
                    end
                    default: S_AXI_BRESP <= `LCDCD_RESP_SLVERR;
                endcase
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    wire [5:0] code_rd = (code_idx_r < NUM_CH) ? latch_mem[code_idx_r] : 6'h00;
    wire [31:0] status_word = {16'h0000, ptr_r, 3'h0, sel300, dir_right, start_out_r, state_r};

    always @(posedge CLK) begin
        if (SRST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `LCDCD_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= `LCDCD_RESP_OKAY;
                case (S_AXI_ARADDR)
                    `LCDCD_OFF_CTRL: S_AXI_RDATA <= {31'h00000000, load_en_r};
                    `LCDCD_OFF_STATUS: S_AXI_RDATA <= status_word;
                    `LCDCD_OFF_LINES: S_AXI_RDATA <= {16'h0000, lines_r};
                    `LCDCD_OFF_CODE_IDX: S_AXI_RDATA <= {23'h000000, code_idx_r};
                    `LCDCD_OFF_CODE_RD: S_AXI_RDATA <= {26'h0000000, code_rd};
                    default: begin
                        S_AXI_RDATA <= 32'h00000000;
                        S_AXI_RRESP <= `LCDCD_RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule
